/* File: ppcb_pkg.sv */
// shared constants and types for the phase pwm compare buffers
package ppcb_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_CMP_U = 8'h00;
	localparam logic [7:0] OFS_CMP_V = 8'h04;
	localparam logic [7:0] OFS_PERIOD = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned MODE_TRI_BIT = 0;
	localparam int unsigned MODE_CLKSEL_BIT = 1;
	localparam int unsigned MODE_TIMING_LSB = 2;
	localparam int unsigned MODE_RUN_BIT = 4;
	localparam logic [1:0] TIMING_HALF = 2'h0;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [15:0] PRD_RST = 16'h0000;
	localparam logic [15:0] PRD_MIN = 16'h0010;
	localparam logic [4:0] MODE_RST = 5'h00;

	// ----------------------------------------------------------------
	// count resolution, given at the 80 MHz reference system clock
	// ----------------------------------------------------------------
	localparam int unsigned REF_MHZ = 80;
	localparam int unsigned RES_SAW_FAST_PS = 12500;
	localparam int unsigned RES_TRI_FAST_PS = 25000;
	localparam int unsigned RES_SAW_SLOW_PS = 50000;
	localparam int unsigned RES_TRI_SLOW_PS = 100000;
	localparam logic [3:0] DIV_SAW_FAST =
		4'(RES_SAW_FAST_PS * REF_MHZ / 1000000);
	localparam logic [3:0] DIV_TRI_FAST =
		4'(RES_TRI_FAST_PS * REF_MHZ / 1000000);
	localparam logic [3:0] DIV_SAW_SLOW =
		4'(RES_SAW_SLOW_PS * REF_MHZ / 1000000);
	localparam logic [3:0] DIV_TRI_SLOW =
		4'(RES_TRI_SLOW_PS * REF_MHZ / 1000000);

	typedef enum logic {PPCB_DIR_UP, PPCB_DIR_DOWN} ppcb_dir_e;

endpackage

/* File: ppcb_cmp_if.sv */
// shared counter, transfer strobe and write data toward compare channels
`timescale 1ns/1ns
interface ppcb_cmp_if;
	logic [15:0] cnt;
	logic xfer;
	logic [15:0] wdata;
	modport ctrl (output cnt, output xfer, output wdata);
	modport chan (input cnt, input xfer, input wdata);
endinterface

/* File: ppcb_tick.sv */
// count tick prescaler
`timescale 1ns/1ns
module ppcb_tick
	import ppcb_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [3:0] div,
	input wire logic restart,
	output logic tick
);

	logic [3:0] cnt_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 4'h0;
		end else if (restart || cnt_r == 4'h0) begin
			cnt_r <= 4'(div - 4'h1);
		end else begin
			cnt_r <= 4'(cnt_r - 4'h1);
		end
	end

	assign tick = (cnt_r == 4'h0) && !restart;

endmodule

/* File: ppcb_channel.sv */
// one double-buffered compare channel
`timescale 1ns/1ns
module ppcb_channel
	import ppcb_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	ppcb_cmp_if.chan bus,
	input wire logic wr_en,
	output logic [15:0] buf_val,
	output logic [15:0] act_val,
	output logic pwm_out
);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			buf_val <= CMP_RST;
		end else if (wr_en) begin
			buf_val <= bus.wdata;
		end
	end

	// a write in a transfer cycle lands at the next transfer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			act_val <= CMP_RST;
		end else if (bus.xfer) begin
			act_val <= buf_val;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pwm_out <= 1'b0;
		end else begin
			pwm_out <= bus.cnt < act_val;
		end
	end

	hold_active_a: assert property (!bus.xfer |=> $stable(act_val))
		else $error("active compare changed without transfer");

endmodule

/* File: ppcb_top.sv */
// phase pwm compare buffers: registers, shared counter, u and v channels
// Behaviour
// - compare registers hold 16-bit width value low; upper bits read zero
// - clock select clear: count step 12.5ns sawtooth, 25ns triangle at 80MHz
// - clock select set: count step 50ns sawtooth, 100ns triangle at 80MHz
// - u active compare value sets u-phase pulse width
// - pulse formed by comparing active value against running counter
// - values double-buffered; writes never disturb active comparison
// - buffer copied to active latch when counter equals period
// - half-cycle timing code 00 also copies when counter equals one
// - reading a compare register returns the buffered value
// - shared counter is 16-bit read-only count of ticks
// - period below 0x10 counts as 0x10, written value reads back
`timescale 1ns/1ns
module ppcb_top
	import ppcb_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_strobe,
	input wire logic rd_strobe,
	output logic [31:0] rd_data,
	output logic pwm_u,
	output logic pwm_v,
	output logic period_match
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam int unsigned NCH = 2;

	ppcb_cmp_if cmp_bus ();

	logic [15:0] prd_r;
	logic tri_r;
	logic clksel_r;
	logic [1:0] timing_r;
	logic run_r;
	logic [15:0] cnt_r;
	ppcb_dir_e dir_r;
	logic [31:0] rd_data_r;
	logic [15:0] prd_eff;
	logic [3:0] div;
	logic tick;
	logic restart;
	logic mode_wr;
	logic at_top;
	logic at_one;
	logic xfer;
	logic [NCH-1:0] wr_ch;
	logic [NCH-1:0] pwm_ch;
	logic [15:0] buf_val [NCH];
	logic [15:0] act_val [NCH];

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// byte lanes are not decoded; partial accesses are not supported
	assign wr_ch[0] = wr_strobe && addr == OFS_CMP_U;
	assign wr_ch[1] = wr_strobe && addr == OFS_CMP_V;
	assign mode_wr = wr_strobe && addr == OFS_MODE;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prd_r <= PRD_RST;
		end else if (wr_strobe && addr == OFS_PERIOD) begin
			prd_r <= wr_data[15:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			{run_r, timing_r, clksel_r, tri_r} <= MODE_RST;
		end else if (mode_wr) begin
			tri_r <= wr_data[MODE_TRI_BIT];
			clksel_r <= wr_data[MODE_CLKSEL_BIT];
			timing_r <= wr_data[MODE_TIMING_LSB +: 2];
			run_r <= wr_data[MODE_RUN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_r <= 32'h0000_0000;
		end else if (rd_strobe) begin
			case (addr)
				OFS_CMP_U: rd_data_r <= {16'h0000, buf_val[0]};
				OFS_CMP_V: rd_data_r <= {16'h0000, buf_val[1]};
				OFS_PERIOD: rd_data_r <= {16'h0000, prd_r};
				OFS_MODE: rd_data_r <= {27'h0000000, run_r, timing_r,
					clksel_r, tri_r};
				OFS_COUNT: rd_data_r <= {16'h0000, cnt_r};
				default: rd_data_r <= 32'h0000_0000;
			endcase
		end else begin
			rd_data_r <= 32'h0000_0000;
		end
	end

	assign rd_data = rd_data_r;

	// ----------------------------------------------------------------
	// count resolution
	// ----------------------------------------------------------------
	always_comb begin
		case ({clksel_r, tri_r})
			2'b00: div = DIV_SAW_FAST;
			2'b01: div = DIV_TRI_FAST;
			2'b10: div = DIV_SAW_SLOW;
			2'b11: div = DIV_TRI_SLOW;
			default: div = DIV_SAW_FAST;
		endcase
	end

	// restart realigns the prescaler; the first step after a mode write still has the old resolution's length
	assign restart = !run_r || mode_wr;

	ppcb_tick u_tick (
		.clock(clock),
		.reset_n(reset_n),
		.div(div),
		.restart(restart),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// shared counter
	// ----------------------------------------------------------------
	assign prd_eff = (prd_r < PRD_MIN) ? PRD_MIN : prd_r;
	// >= so a period lowered below the count still wraps at once
	assign at_top = cnt_r >= prd_eff;
	assign at_one = cnt_r == 16'h0001;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 16'h0000;
			dir_r <= PPCB_DIR_UP;
		end else if (!run_r) begin
			cnt_r <= 16'h0000;
			dir_r <= PPCB_DIR_UP;
		end else if (tick) begin
			if (!tri_r) begin
				cnt_r <= at_top ? 16'h0000 : 16'(cnt_r + 16'h0001);
				dir_r <= PPCB_DIR_UP;
			end else begin
				case (dir_r)
					PPCB_DIR_UP: begin
						if (at_top) begin
							cnt_r <= 16'(prd_eff - 16'h0001);
							dir_r <= PPCB_DIR_DOWN;
						end else begin
							cnt_r <= 16'(cnt_r + 16'h0001);
						end
					end
					PPCB_DIR_DOWN: begin
						if (cnt_r == 16'h0000) begin
							cnt_r <= 16'h0001;
							dir_r <= PPCB_DIR_UP;
						end else begin
							cnt_r <= 16'(cnt_r - 16'h0001);
						end
					end
					default: begin
						cnt_r <= 16'h0000;
						dir_r <= PPCB_DIR_UP;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// buffer to latch transfer
	// ----------------------------------------------------------------
	assign xfer = run_r && tick &&
		(cnt_r == prd_eff || (timing_r == TIMING_HALF && at_one));
	assign period_match = run_r && tick && cnt_r == prd_eff;

	assign cmp_bus.cnt = cnt_r;
	assign cmp_bus.xfer = xfer;
	assign cmp_bus.wdata = wr_data[15:0];

	// ----------------------------------------------------------------
	// compare channels: 0 = u phase, 1 = v phase
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		ppcb_channel u_ch (
			.clock(clock),
			.reset_n(reset_n),
			.bus(cmp_bus.chan),
			.wr_en(wr_ch[ch]),
			.buf_val(buf_val[ch]),
			.act_val(act_val[ch]),
			.pwm_out(pwm_ch[ch])
		);
	end

	assign pwm_u = pwm_ch[0];
	assign pwm_v = pwm_ch[1];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [3:0] gap_r;
	logic cfg_chg_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gap_r <= 4'h0;
		end else if (tick) begin
			gap_r <= 4'h1;
		end else if (gap_r != 4'hF) begin
			gap_r <= 4'(gap_r + 4'h1);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg_chg_r <= 1'b1;
		end else if (restart) begin
			cfg_chg_r <= 1'b1;
		end else if (tick) begin
			cfg_chg_r <= 1'b0;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence s_read(logic [7:0] a);
		rd_strobe && addr == a;
	endsequence

	sequence s_top_tick;
		run_r && tick && cnt_r == prd_eff;
	endsequence

	sequence s_one_tick;
		run_r && tick && timing_r == TIMING_HALF && cnt_r == 16'h0001;
	endsequence

	read_upper_zero_a: assert property (
		s_read(OFS_CMP_U) or s_read(OFS_CMP_V) |=> rd_data[31:16] == 16'h0)
		else $error("compare read upper half not zero");

	fast_step_a: assert property (
		tick && !cfg_chg_r && !clksel_r |->
		gap_r == (tri_r ? DIV_TRI_FAST : DIV_SAW_FAST))
		else $error("fast resolution tick spacing wrong");

	slow_step_a: assert property (
		tick && !cfg_chg_r && clksel_r |->
		gap_r == (tri_r ? DIV_TRI_SLOW : DIV_SAW_SLOW))
		else $error("slow resolution tick spacing wrong");

	u_pulse_a: assert property (
		##1 pwm_u == ($past(cnt_r) < $past(act_val[0])))
		else $error("u pulse disagrees with compare");

	v_pulse_a: assert property (
		##1 pwm_v == ($past(cnt_r) < $past(act_val[1])))
		else $error("v pulse disagrees with compare");

	period_copy_a: assert property (
		s_top_tick |=> act_val[0] == $past(buf_val[0]) &&
		act_val[1] == $past(buf_val[1]))
		else $error("no transfer at period match");

	half_copy_a: assert property (
		s_one_tick |=> act_val[0] == $past(buf_val[0]) &&
		act_val[1] == $past(buf_val[1]))
		else $error("no transfer at count one");

	read_buffer_a: assert property (
		s_read(OFS_CMP_U) |=> rd_data[15:0] == $past(buf_val[0]))
		else $error("compare read not from buffer");

	read_buffer_v_a: assert property (
		s_read(OFS_CMP_V) |=> rd_data[15:0] == $past(buf_val[1]))
		else $error("v compare read not from buffer");

	count_read_a: assert property (
		s_read(OFS_COUNT) |=> rd_data == {16'h0000, $past(cnt_r)})
		else $error("counter read wrong");

	min_period_a: assert property (
		run_r && tick && !tri_r && prd_r < PRD_MIN &&
		cnt_r == 16'(PRD_MIN - 16'h0001) |=> cnt_r == PRD_MIN)
		else $error("short period not extended");

	// triangle turns at the clamped period, not at the written one
	tri_turn_a: assert property (
		run_r && tick && tri_r && dir_r == PPCB_DIR_UP &&
		prd_r < PRD_MIN && cnt_r == PRD_MIN |=>
		cnt_r == 16'(PRD_MIN - 16'h0001))
		else $error("short period not extended in triangle");

endmodule

/* File: ppcb_gate_drive.sv */
// gate drive stage model: high samples of each phase per pwm period
`timescale 1ns/1ns
module ppcb_gate_drive (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic pwm_u,
	input wire logic pwm_v,
	input wire logic period_match,
	output logic [15:0] width_u,
	output logic [15:0] width_v
);
	logic [15:0] cnt_u_r;
	logic [15:0] cnt_v_r;

	// ----------------------------------------------------------------
	// pulse width measurement
	// ----------------------------------------------------------------
	// window closes on the period event; the pulse sits well inside it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_u_r <= 16'h0000;
			cnt_v_r <= 16'h0000;
			width_u <= 16'h0000;
			width_v <= 16'h0000;
		end else if (period_match) begin
			width_u <= cnt_u_r;
			width_v <= cnt_v_r;
			cnt_u_r <= 16'h0000;
			cnt_v_r <= 16'h0000;
		end else begin
			cnt_u_r <= cnt_u_r + 16'(pwm_u);
			cnt_v_r <= cnt_v_r + 16'(pwm_v);
		end
	end
endmodule

/* File: tb.sv */
// self-checking bench for the phase pwm compare buffers
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	import ppcb_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_strobe = 1'b0;
	logic rd_strobe = 1'b0;
	logic [31:0] rd_data;
	logic pwm_u;
	logic pwm_v;
	logic period_match;
	logic [15:0] width_u;
	logic [15:0] width_v;
	int miscompares = 0;
	int n_compared = 0;
	int seed = 61931;
	int n;
	logic [31:0] d;
	logic [31:0] v;
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] cur;

	ppcb_top ppcb_top_inst (.clock(clock), .reset_n(reset_n), .addr(addr),
		.wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.rd_data(rd_data), .pwm_u(pwm_u), .pwm_v(pwm_v),
		.period_match(period_match));
	ppcb_gate_drive ppcb_gate_drive_inst (.clock(clock), .reset_n(reset_n),
		.pwm_u(pwm_u), .pwm_v(pwm_v), .period_match(period_match),
		.width_u(width_u), .width_v(width_v));

	initial forever #25 clock = ~clock;

	// ----------------------------------------------------------------
	// bus tasks, entered just after a rising edge
	// ----------------------------------------------------------------
	// the idle cycle after each strobe keeps back-to-back calls legal
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		addr <= ad;
		wr_data <= wd;
		wr_strobe <= 1'b1;
		@(posedge clock);
		wr_strobe <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] q);
		addr <= ad;
		rd_strobe <= 1'b1;
		@(posedge clock);
		rd_strobe <= 1'b0;
		#1 q = rd_data;
		@(posedge clock);
	endtask

	task automatic chk_rd(input logic [7:0] ad, input logic [31:0] e);
		rd(ad, d);
		`CHK(d, e)
	endtask

	// returns just after the edge that samples the period event
	task automatic wait_pm();
		for (int i = 0; i < 400; i++) begin
			@(negedge clock);
			if (period_match === 1'b1) break;
		end
		@(posedge clock);
	endtask

	function automatic logic [15:0] rnd_w();
		return 16'(2 + {$random(seed)} % 11);
	endfunction

	// cycles between period events at the clamped period
	function automatic int exp_gap(input int m);
		return ((m & 1) ? 2 * int'(PRD_MIN) : int'(PRD_MIN) + 1) * (1 << m);
	endfunction

	task automatic report_and_stop();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		miscompares++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		chk_rd(OFS_CMP_U, 32'h0);
		chk_rd(OFS_CMP_V, 32'h0);
		wr(OFS_COUNT, 32'hFFFF);
		chk_rd(OFS_COUNT, 32'h0);
		chk_rd(8'h14, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(OFS_CMP_U, v);
			wr(OFS_CMP_V, ~v);
			chk_rd(OFS_CMP_U, {16'h0000, v[15:0]});
			chk_rd(OFS_CMP_V, {16'h0000, ~v[15:0]});
		end
		wr(OFS_PERIOD, 32'h5);
		chk_rd(OFS_PERIOD, 32'h5);
		a = rnd_w();
		b = rnd_w();
		wr(OFS_CMP_U, {16'h0000, a});
		wr(OFS_CMP_V, {16'h0000, b});
		wr(OFS_MODE, 32'h14);
		repeat (3) wait_pm();
		#1 `CHK(width_u, a)
		`CHK(width_v, b)
		// written while running, but a writable counter would wrap to zero at the next tick, before the read
		wr(OFS_COUNT, 32'hFFFF);
		rd(OFS_COUNT, d);
		`CHK(d <= 32'h10, 1'b1)
		cur = a;
		for (int t = 1; t >= 0; t--) begin
			wr(OFS_MODE, 32'h10 | (32'(t) << 2));
			repeat (2) wait_pm();
			a = rnd_w();
			wait_pm();
			wr(OFS_CMP_U, {16'h0000, a});
			chk_rd(OFS_CMP_U, {16'h0000, a});
			wait_pm();
			#1 `CHK(width_u, (t == 1) ? cur : a)
			wait_pm();
			#1 `CHK(width_u, a)
			cur = a;
		end
		for (int m = 0; m < 4; m++) begin
			wr(OFS_MODE, 32'h14 | 32'(m));
			repeat (2) wait_pm();
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while (period_match !== 1'b1);
			`CHK(n, exp_gap(m))
			@(posedge clock);
		end
		// second reset mid-run clears buffers, period and counter
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		chk_rd(OFS_CMP_U, 32'h0);
		chk_rd(OFS_PERIOD, 32'h0);
		chk_rd(OFS_COUNT, 32'h0);
		`CHK({pwm_u, pwm_v}, 2'b00)
		report_and_stop();
	end
endmodule
